// file: pwsm_cnt_if.sv
// counter control and result signals between top and counter
`timescale 1ns/10ps
`default_nettype none
interface pwsm_cnt_if;
  logic advance;
  logic restart;
  logic [5:0] limit;
  logic [5:0] count;
  logic hit;
  modport ctl (output advance, output restart, output limit, input count, input hit);
  modport cnt (input advance, input restart, input limit, output count, output hit);
endinterface
`default_nettype wire

// file: pwsm_core_model.sv
// core-side model: clock restart, power-on style exit and vector tallies
`timescale 1ns/10ps
`default_nettype none
module pwsm_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // unit requests and mode
  input wire logic light_stop_mode,
  input wire logic clk_restart_req,
  input wire logic periodic_reset_req,
  input wire logic por_exit_req,
  input wire logic por_only_status,
  // core answers and tallies
  output logic clk_ready,
  output logic por_from_stop,
  output logic bad_order,
  output logic [7:0] n_reset,
  output logic [7:0] n_restart,
  output logic [7:0] n_por_only
);
  logic lsm_q;
  logic [2:0] dly;

  // clocks stop on entering light stop, return four cycles after a restart request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsm_q <= 1'h0;
      dly <= 3'h0;
      clk_ready <= 1'h1;
      por_from_stop <= 1'h0;
      bad_order <= 1'h0;
      n_reset <= 8'h00;
      n_restart <= 8'h00;
      n_por_only <= 8'h00;
    end else begin
      lsm_q <= light_stop_mode;
      if (light_stop_mode && !lsm_q) clk_ready <= 1'h0;
      else if (dly == 3'h1) clk_ready <= 1'h1;
      if (clk_restart_req) dly <= 3'h4;
      else if (dly != 3'h0) dly <= dly - 3'h1;
      // a deep stop exit comes back as a power-on reset marked as stop exit
      por_from_stop <= por_exit_req;
      // a vector taken while clocks are still off would be lost in silicon
      if (periodic_reset_req && !clk_ready) bad_order <= 1'h1;
      n_reset <= n_reset + {7'h0, periodic_reset_req};
      n_restart <= n_restart + {7'h0, clk_restart_req};
      n_por_only <= n_por_only + {7'h0, por_only_status};
    end
  end
endmodule // pwsm_core_model
`default_nettype wire

// file: pwsm_counter.sv
// one 6-bit interval counter with terminal-count restart
`timescale 1ns/10ps
`default_nettype none
module pwsm_counter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control and result
  pwsm_cnt_if.cnt cif
);

  pwsm_pkg::pwsm_cnt_state_t st_ff;
  pwsm_pkg::pwsm_cnt_state_t nxt_st;

  // terminal detect: a zero limit disables the counter
  assign cif.hit = cif.advance && (cif.limit != 6'h00) &&
                   (st_ff.count == (cif.limit - 6'h01));
  assign cif.count = st_ff.count;

  // next count: restart wins, terminal wraps to zero
  always_comb begin
    nxt_st = st_ff;
    if (cif.restart || cif.limit == 6'h00) begin
      nxt_st.count = 6'h00;
    end else if (cif.hit) begin
      nxt_st.count = 6'h00;
    end else if (cif.advance) begin
      nxt_st.count = st_ff.count + 6'h01;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // pwsm_counter
`default_nettype wire

// file: pwsm_pkg.sv
// constants, register map and state types of the periodic wake-up status block
package pwsm_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS = 8'h1F;
  localparam logic [7:0] IDX_WU_CTRL = 8'h20;
  localparam logic [7:0] IDX_PR_CTRL = 8'h21;
  localparam logic [7:0] IDX_EVT_STAT = 8'h22;
  localparam logic [7:0] IDX_EVT_CLR = 8'h23;
  localparam logic [7:0] IDX_EVT_EN = 8'h24;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam int POS_PSEL = 7;
  localparam int POS_UNUSED = 6;
  localparam int POS_WU = 0;
  localparam int POS_PR = 1;
  localparam logic RST_PSEL = 1'b0;
  localparam logic [5:0] RST_LIMIT = 6'h3F;
  localparam logic [1:0] RST_EN = 2'h0;

  // whole register state of the top block
  typedef struct packed {
    logic psel;
    logic [5:0] snap;
    logic [5:0] wu_lim;
    logic [5:0] pr_lim;
    logic [1:0] flags;
    logic [1:0] irq_en;
    logic pr_pend;
    logic wait_req;
    logic [31:0] rdata;
    logic irq;
    logic clk_restart;
    logic periodic_reset_count_req;
    logic por_exit;
    logic por_only;
  } pwsm_state_t;

  // state of one interval counter
  typedef struct packed {
    logic [5:0] count;
  } pwsm_cnt_state_t;

endpackage

// file: pwsm_top.sv
// periodic wake-up unit: counters, status readback, power-mode event routing
`timescale 1ns/10ps
`default_nettype none
module pwsm_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // wake clock tick and core state
  input wire logic wake_tick,
  input wire logic debug_freeze,
  input wire logic light_stop_mode,
  input wire logic deep_stop_mode,
  input wire logic clk_ready,
  input wire logic core_por,
  input wire logic core_por_from_stop,
  // requests to the core
  output logic irq,
  output logic clk_restart_req,
  output logic periodic_reset_req,
  output logic por_exit_req,
  output logic por_only_status
);

  // ----------------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------------
  pwsm_pkg::pwsm_state_t st_ff;
  pwsm_pkg::pwsm_state_t nxt_st;

  pwsm_cnt_if wu_if ();
  pwsm_cnt_if pr_if ();

  pwsm_counter u_wu_cnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cif(wu_if.cnt)
  );

  pwsm_counter u_pr_cnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cif(pr_if.cnt)
  );

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic bus_req;
  logic bus_take;
  logic bus_done;
  logic [7:0] bus_idx;
  logic wr_lane0;
  logic true_por;
  logic [5:0] sel_count;
  logic wu_change;
  logic pr_change;
  logic [1:0] clr_bits;
  logic vec_hold;

  // first request cycle takes, second answers with waitrequest low
  assign bus_req = avs_read || avs_write;
  assign bus_take = bus_req && st_ff.wait_req;
  assign bus_done = bus_req && !st_ff.wait_req;
  assign bus_idx = avs_address[9:2];
  assign wr_lane0 = bus_done && avs_write && avs_byteenable[0];
  // a power-on that came out of deep stop must not wipe programmed state
  assign true_por = core_por && !core_por_from_stop;
  assign sel_count = st_ff.psel ? pr_if.count : wu_if.count;

  // interval writes: same data is no change; both zero is refused
  assign wu_change = wr_lane0 && bus_idx == pwsm_pkg::IDX_WU_CTRL &&
                     avs_writedata[5:0] != st_ff.wu_lim &&
                     !(avs_writedata[5:0] == 6'h00 && st_ff.pr_lim == 6'h00);
  assign pr_change = wr_lane0 && bus_idx == pwsm_pkg::IDX_PR_CTRL &&
                     avs_writedata[5:0] != st_ff.pr_lim &&
                     !(avs_writedata[5:0] == 6'h00 && st_ff.wu_lim == 6'h00);
  assign clr_bits = (wr_lane0 && bus_idx == pwsm_pkg::IDX_EVT_CLR) ?
                    avs_writedata[1:0] : 2'h0;
  // in light stop no vector may be presented before clocks are back
  assign vec_hold = light_stop_mode && !clk_ready;

  // ----------------------------------------------------------------------
  // counter control
  // ----------------------------------------------------------------------
  // counters stop during debug so intervals do not drift under a probe
  assign wu_if.advance = wake_tick && !debug_freeze;
  assign wu_if.restart = wu_change || true_por;
  assign wu_if.limit = st_ff.wu_lim;
  assign pr_if.advance = wu_if.hit;
  assign pr_if.restart = pr_change || true_por;
  assign pr_if.limit = st_ff.pr_lim;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wait_req = !bus_take;
    nxt_st.clk_restart = 1'b0;
    nxt_st.periodic_reset_count_req = 1'b0;
    nxt_st.por_exit = 1'b0;
    nxt_st.por_only = 1'b0;
    // read path: capture selected counter on the take cycle
    if (bus_take && avs_read) begin
      nxt_st.rdata = 32'h0000_0000;
      unique case (bus_idx)
        pwsm_pkg::IDX_STATUS: begin
          nxt_st.snap = sel_count;
          nxt_st.rdata[pwsm_pkg::POS_PSEL] = st_ff.psel;
          nxt_st.rdata[pwsm_pkg::POS_UNUSED] = 1'b0;
          nxt_st.rdata[5:0] = sel_count;
        end
        pwsm_pkg::IDX_WU_CTRL: nxt_st.rdata[5:0] = st_ff.wu_lim;
        pwsm_pkg::IDX_PR_CTRL: nxt_st.rdata[5:0] = st_ff.pr_lim;
        pwsm_pkg::IDX_EVT_STAT: nxt_st.rdata[1:0] = st_ff.flags;
        pwsm_pkg::IDX_EVT_EN: nxt_st.rdata[1:0] = st_ff.irq_en;
        default: nxt_st.rdata = 32'h0000_0000; // clear register and holes read zero
      endcase
    end
    // write path: only bit 7 of status is writable
    if (wr_lane0 && bus_idx == pwsm_pkg::IDX_STATUS) begin
      nxt_st.psel = avs_writedata[pwsm_pkg::POS_PSEL];
    end
    if (wu_change) begin
      nxt_st.wu_lim = avs_writedata[5:0];
    end
    if (pr_change) begin
      nxt_st.pr_lim = avs_writedata[5:0];
    end
    if (wr_lane0 && bus_idx == pwsm_pkg::IDX_EVT_EN) begin
      nxt_st.irq_en = avs_writedata[1:0];
    end
    // flags: a hit in the clearing cycle wins over the clear
    nxt_st.flags[pwsm_pkg::POS_WU] = (st_ff.flags[pwsm_pkg::POS_WU] &&
                                      !clr_bits[pwsm_pkg::POS_WU]) ||
                                     wu_if.hit;
    nxt_st.flags[pwsm_pkg::POS_PR] = (st_ff.flags[pwsm_pkg::POS_PR] &&
                                      !clr_bits[pwsm_pkg::POS_PR]) ||
                                     pr_if.hit;
    // power-mode routing of events; registers are left untouched
    if (wu_if.hit || pr_if.hit) begin
      if (light_stop_mode) begin
        nxt_st.clk_restart = 1'b1;
      end
      if (deep_stop_mode) begin
        nxt_st.por_exit = 1'b1;
        nxt_st.por_only = pr_if.hit;
      end
    end
    if (pr_if.hit && !deep_stop_mode) begin
      if (vec_hold) begin
        nxt_st.pr_pend = 1'b1;
      end else begin
        nxt_st.periodic_reset_count_req = 1'b1;
      end
    end else if (st_ff.pr_pend && !vec_hold) begin
      nxt_st.periodic_reset_count_req = 1'b1;
      nxt_st.pr_pend = 1'b0;
    end
    // genuine power-on: page select and intervals back to reset values, flags cleared; interrupt enables kept
    if (true_por) begin
      nxt_st.psel = pwsm_pkg::RST_PSEL;
      nxt_st.wu_lim = pwsm_pkg::RST_LIMIT;
      nxt_st.pr_lim = pwsm_pkg::RST_LIMIT;
      nxt_st.flags = pwsm_pkg::RST_EN;
      nxt_st.pr_pend = 1'b0;
    end
    // wake-up stays pending through a deep stop exit until acknowledged
    // taken after the power-on clear so no stale interrupt outlives it
    nxt_st.irq = |(nxt_st.flags & st_ff.irq_en) && !vec_hold;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.psel <= pwsm_pkg::RST_PSEL;
      st_ff.wu_lim <= pwsm_pkg::RST_LIMIT;
      st_ff.pr_lim <= pwsm_pkg::RST_LIMIT;
      st_ff.irq_en <= pwsm_pkg::RST_EN;
      st_ff.wait_req <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;
  assign irq = st_ff.irq;
  assign clk_restart_req = st_ff.clk_restart;
  assign periodic_reset_req = st_ff.periodic_reset_count_req;
  assign por_exit_req = st_ff.por_exit;
  assign por_only_status = st_ff.por_only;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_status_mux: assert property (bus_take && avs_read && bus_idx == pwsm_pkg::IDX_STATUS
    |=> avs_readdata[5:0] == ($past(st_ff.psel) ? $past(pr_if.count) : $past(wu_if.count)))
    else $error("status field does not show selected counter");
  a_psel_hold: assert property (!true_por && !(wr_lane0 && bus_idx == pwsm_pkg::IDX_STATUS)
    |=> $stable(st_ff.psel))
    else $error("page select changed without write or power-on");
  a_unused_zero: assert property (!avs_waitrequest |-> avs_readdata[6] == 1'b0)
    else $error("unused status bit read as one");
  a_count_restart: assert property (wu_if.hit && !true_por |=> wu_if.count == 6'h00)
    else $error("counter did not restart after event");
  a_wu_flag_set: assert property (wu_if.hit |=> st_ff.flags[pwsm_pkg::POS_WU])
    else $error("wake-up flag not set with terminal count");
  a_pr_vector: assert property (pr_if.hit && !deep_stop_mode && !vec_hold
    |=> periodic_reset_req && st_ff.flags[pwsm_pkg::POS_PR])
    else $error("periodic reset not requested");
  a_light_restart: assert property (light_stop_mode && wu_if.hit |=> clk_restart_req)
    else $error("clock restart missing in light stop");
  a_light_order: assert property (vec_hold && !st_ff.irq |=> !irq)
    else $error("vector raised before clocks restarted");
  a_deep_exit: assert property (deep_stop_mode && pr_if.hit
    |=> por_exit_req && por_only_status && !periodic_reset_req)
    else $error("deep stop periodic exit wrong");
  a_deep_keep: assert property (core_por && core_por_from_stop && !bus_done
    |=> $stable(st_ff.wu_lim) && $stable(st_ff.pr_lim) && $stable(st_ff.psel))
    else $error("deep stop exit lost programmed intervals");
  a_freeze: assert property (debug_freeze && !wu_if.restart && wu_if.limit != 6'h00
    |=> $stable(wu_if.count))
    else $error("counter moved during debug");
  a_bus_answer: assert property (bus_take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after take");

  c_wu_event: cover property (wu_if.hit);
  c_pr_event: cover property (pr_if.hit ##[1:8] periodic_reset_req);
  c_deep_exit: cover property (por_exit_req && por_only_status);
  c_page_read: cover property (bus_take && avs_read && st_ff.psel);

endmodule // pwsm_top
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the periodic wake-up status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wake_tick = 1'h0;
  logic debug_freeze = 1'h0;
  logic light_stop_mode = 1'h0;
  logic deep_stop_mode = 1'h0;
  logic tb_por = 1'h0;
  logic clk_ready, por_from_stop, bad_order, irq, clk_restart_req;
  logic periodic_reset_req, por_exit_req, por_only_status;
  logic [7:0] n_reset, n_restart, n_por_only;
  int err_count = 0;
  int compares = 0;
  int n;
  logic [7:0] n_por_exit = 8'h00;

  // tally of power-on style exit requests seen by the core
  always @(posedge sys_clk) begin
    if (por_exit_req === 1'h1) n_por_exit <= n_por_exit + 8'h01;
  end

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  pwsm_core_model i_core (.sys_clk(sys_clk), .rst_n(rst_n), .light_stop_mode(light_stop_mode),
    .clk_restart_req(clk_restart_req), .periodic_reset_req(periodic_reset_req),
    .por_exit_req(por_exit_req), .por_only_status(por_only_status), .clk_ready(clk_ready),
    .por_from_stop(por_from_stop), .bad_order(bad_order), .n_reset(n_reset),
    .n_restart(n_restart), .n_por_only(n_por_only));

  pwsm_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .wake_tick(wake_tick), .debug_freeze(debug_freeze), .light_stop_mode(light_stop_mode),
    .deep_stop_mode(deep_stop_mode), .clk_ready(clk_ready), .core_por(tb_por | por_from_stop),
    .core_por_from_stop(por_from_stop), .irq(irq), .clk_restart_req(clk_restart_req),
    .periodic_reset_req(periodic_reset_req), .por_exit_req(por_exit_req),
    .por_only_status(por_only_status));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task results;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access; waitrequest and read data are taken at the rising edge itself
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    logic done;
    int k;
    avs_address <= {idx, 2'h0};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    done = 1'h0;
    rd = 32'h0;
    for (k = 0; !done; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'h0) begin
        done = 1'h1;
        rd = avs_readdata;
      end else if (k > 50) begin
        err_count++;
        results();
      end
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge sys_clk);
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'h1, idx, d, x);
  endtask

  task rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'h0, idx, 8'h00, x);
    chk(what, x, exp);
  endtask

  task tick(input int cnt);
    repeat (cnt) begin
      wake_tick <= 1'h1;
      @(posedge sys_clk);
      wake_tick <= 1'h0;
      @(posedge sys_clk);
    end
  endtask

  // levels as they stood at the last edge; callers run right after an edge
  task pin(input string what, input logic seen_now, input logic exp);
    chk(what, {31'h0, seen_now}, {31'h0, exp});
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd("status", pwsm_pkg::IDX_STATUS, 32'h0);
    rd("wake interval", pwsm_pkg::IDX_WU_CTRL, 32'h3F);
    rd("events", pwsm_pkg::IDX_EVT_STAT, 32'h0);
    wr(8'h30, 8'hFF);
    rd("unmapped", 8'h30, 32'h0);
    // unused bit and count field ignore writes
    wr(pwsm_pkg::IDX_STATUS, 8'hFF);
    rd("status", pwsm_pkg::IDX_STATUS, 32'h80);
    wr(pwsm_pkg::IDX_STATUS, 8'h00);
    wr(pwsm_pkg::IDX_WU_CTRL, 8'h04);
    wr(pwsm_pkg::IDX_PR_CTRL, 8'h02);
    wr(pwsm_pkg::IDX_EVT_EN, 8'h03);
    tick(3);
    rd("wake count", pwsm_pkg::IDX_STATUS, 32'h03);
    tick(1);
    rd("events", pwsm_pkg::IDX_EVT_STAT, 32'h01);
    pin("irq", irq, 1'h1);
    rd("count after event", pwsm_pkg::IDX_STATUS, 32'h00);
    wr(pwsm_pkg::IDX_STATUS, 8'h80);
    rd("periodic count", pwsm_pkg::IDX_STATUS, 32'h81);
    // counters stand still under debug
    debug_freeze <= 1'h1;
    tick(2);
    debug_freeze <= 1'h0;
    wr(pwsm_pkg::IDX_STATUS, 8'h00);
    rd("frozen count", pwsm_pkg::IDX_STATUS, 32'h00);
    tick(2);
    rd("resumed count", pwsm_pkg::IDX_STATUS, 32'h02);
    // rewriting the same interval must not restart the count
    wr(pwsm_pkg::IDX_WU_CTRL, 8'h04);
    rd("same interval", pwsm_pkg::IDX_STATUS, 32'h02);
    wr(pwsm_pkg::IDX_EVT_CLR, 8'h01);
    rd("events", pwsm_pkg::IDX_EVT_STAT, 32'h00);
    pin("irq", irq, 1'h0);
    // second wake-up completes the periodic interval in run mode
    tick(2);
    rd("events", pwsm_pkg::IDX_EVT_STAT, 32'h03);
    pin("reset vector", n_reset === 8'h01, 1'h1);
    rd("wake interval", pwsm_pkg::IDX_WU_CTRL, 32'h04);
    rd("periodic interval", pwsm_pkg::IDX_PR_CTRL, 32'h02);
    wr(pwsm_pkg::IDX_EVT_CLR, 8'h03);
    // light stop: clocks must be back before the reset vector
    wr(pwsm_pkg::IDX_PR_CTRL, 8'h01);
    light_stop_mode <= 1'h1;
    tick(4);
    for (n = 0; n < 40 && n_reset !== 8'h02; n++) @(posedge sys_clk);
    if (n >= 40) begin
      err_count++;
      results();
    end
    light_stop_mode <= 1'h0;
    pin("order", bad_order, 1'h0);
    pin("restarts", n_restart === 8'h01, 1'h1);
    rd("periodic interval", pwsm_pkg::IDX_PR_CTRL, 32'h01);
    wr(pwsm_pkg::IDX_EVT_CLR, 8'h03);
    // deep stop: power-on style exit keeps the unit programmed
    wr(pwsm_pkg::IDX_STATUS, 8'h80);
    deep_stop_mode <= 1'h1;
    tick(4);
    repeat (3) @(posedge sys_clk);
    deep_stop_mode <= 1'h0;
    rd("status", pwsm_pkg::IDX_STATUS, 32'h80);
    rd("wake interval", pwsm_pkg::IDX_WU_CTRL, 32'h04);
    rd("events", pwsm_pkg::IDX_EVT_STAT, 32'h03);
    pin("irq", irq, 1'h1);
    pin("por only", n_por_only === 8'h01, 1'h1);
    pin("por exit", n_por_exit === 8'h01, 1'h1);
    pin("reset vector", n_reset === 8'h02, 1'h1);
    // plain power-on reset clears page select and restores the intervals to reset value
    tb_por <= 1'h1;
    @(posedge sys_clk);
    tb_por <= 1'h0;
    @(posedge sys_clk);
    rd("status", pwsm_pkg::IDX_STATUS, 32'h00);
    rd("wake interval", pwsm_pkg::IDX_WU_CTRL, 32'h3F);
    rd("events", pwsm_pkg::IDX_EVT_STAT, 32'h00);
    pin("irq", irq, 1'h0);
    // zero periodic interval allowed, then zero wake interval refused
    wr(pwsm_pkg::IDX_PR_CTRL, 8'h00);
    wr(pwsm_pkg::IDX_WU_CTRL, 8'h00);
    rd("periodic interval", pwsm_pkg::IDX_PR_CTRL, 32'h00);
    rd("wake interval", pwsm_pkg::IDX_WU_CTRL, 32'h3F);
    // a write without lane 0 enabled is ignored
    avs_byteenable <= 4'hE;
    wr(pwsm_pkg::IDX_EVT_EN, 8'h00);
    avs_byteenable <= 4'hF;
    rd("enables", pwsm_pkg::IDX_EVT_EN, 32'h03);
    results();
  end
endmodule // tb_top
`default_nettype wire
